//--- verilog/flash_protect_consts.svh
// Constants of the write protection and ECC block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FLASH_PROTECT_CONSTS_SVH
`define FLASH_PROTECT_CONSTS_SVH
// Register indices on the plain register port
`define REG_CTRL          4'h0
`define REG_STATUS        4'h1
`define REG_IRQ_STATUS    4'h2
`define REG_IRQ_ENABLE    4'h3
`define REG_IRQ_CLEAR     4'h4
// Control register fields
`define CTRL_PIN_SEL_BIT  0
`define CTRL_PIN_EN_BIT   1
`define CTRL_RESET        2'h0
// Status register fields
`define STAT_LATCH_BIT    0
`define STAT_PDOWN_BIT    1
`define STAT_ECC_EN_BIT   2
`define STAT_LOW_END_BIT  3
`define STAT_SIZE_LSB     4
`define STAT_SINGLE_BIT   8
`define STAT_DOUBLE_BIT   9
// Interrupt event bits
`define IRQ_REJECT_BIT    0
`define IRQ_GUARD_BIT     1
`define IRQ_SINGLE_BIT    2
`define IRQ_DOUBLE_BIT    3
`define IRQ_W             4
// Status write payload fields
`define SW_SIZE_LSB       0
`define SW_LOW_END_BIT    4
`define SW_ECC_EN_BIT     5
// Array geometry
`define ARRAY_AW          25
`define GUARD_MIN_LOG2    16
`define SIZE_ALL_CODE     4'h0
`define SIZE_MAX_CODE     4'h9
`define ERASED_GROUP      64'hFFFF_FFFF_FFFF_FFFF
`define ERASED_CHECK      8'hFF
`define PROTECT_RESET     4'h0
`endif

//--- verilog/flash_protect_pkg.sv
// Types shared by the write protection and ECC block.
// Assumes the constants header sits beside it.
`include "flash_protect_consts.svh"
package flash_protect_pkg;
   // Decoded commands from the serial front end
   typedef enum logic [3:0] {
      CMD_NONE, CMD_LATCH_SET, CMD_LATCH_CLEAR, CMD_STATUS_WRITE, CMD_PAGE_PROG,
      CMD_QUAD_PROG, CMD_SECTOR_WIPE, CMD_BLOCK_WIPE, CMD_ARRAY_WIPE,
      CMD_POWER_DOWN, CMD_POWER_RELEASE, CMD_RESET_ARM, CMD_RESET_GO, CMD_READ
   } cmd_code_t;
   // One command with address and payload
   typedef struct packed {
      logic                   valid;
      cmd_code_t              code;
      logic [`ARRAY_AW-1:0]   addr;
      logic [63:0]            data;
   } cmd_req_t;
   // One 8-byte group read from the array with its check bits
   typedef struct packed {
      logic        valid;
      logic [63:0] data;
      logic [7:0]  check;
   } arr_group_t;
   // Program request toward the array, check bits for the spare area
   typedef struct packed {
      logic                 valid;
      logic                 wipe;
      logic [`ARRAY_AW-1:0] addr;
      logic [63:0]          data;
      logic [7:0]           check;
   } prog_req_t;
   // Power state of the die
   typedef enum { PWR_ACTIVE, PWR_DOWN } pwr_state_t;
endpackage

//--- verilog/flash_write_protect_ecc.sv
// Write permit latch, protected range decode, power-down gating and
// 8-byte SEC-DED ECC engine of one flash die.
// Assumes a serial front end that decodes commands and an array model
// that stores groups and spare check bits; all on one clock.
//
// Summary of operation
// - Latch set command arms the write permit
// - Reset, clear, status write, program, wipe clear latch
// - Guarded region stays readable, never altered
// - Power-down ignores all but release and reset
// - Codes 1-9 guard 64KB doubling, top or bottom
// - Code 0 guards nothing; high codes guard all
// - Hsiao SEC-DED code over aligned 8-byte groups
// - Check bits computed on program, sent to spare
// - Reads corrected singles, doubles flagged
// - Reads start anywhere, one group per request
// - Event pin pulled low during faulty group
// - Erased bytes read as FFH
// - Pin select chooses single or double events
// - Clear latch rejects status write, program, wipe
// - Whole-array wipe only with size bits zero
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_consts.svh"
module flash_write_protect_ecc (
   // Clock and reset
   input  wire logic                          core_clk_in,
   input  wire logic                          nrst_in,
   // Register port
   input  wire logic [3:0]                    reg_addr_in,
   input  wire logic [31:0]                   reg_wdata_in,
   input  wire logic                          reg_wr_in,
   input  wire logic                          reg_rd_in,
   output logic      [31:0]                   reg_rdata_out,
   // Decoded command stream
   input  wire flash_protect_pkg::cmd_req_t   cmd_in,
   output logic                               cmd_accept_out,
   output logic                               cmd_reject_out,
   // Array side
   output flash_protect_pkg::prog_req_t       prog_out,
   input  wire flash_protect_pkg::arr_group_t arr_in,
   // Corrected read data
   output logic                               rd_valid_out,
   output logic      [63:0]                   rd_data_out,
   output logic                               single_fix_flag_out,
   output logic                               double_detect_flag_out,
   // Open-drain event pin and interrupt
   output logic                               ecc_event_pin_o_out,
   output logic                               ecc_event_pin_oe_out,
   output logic                               irq_out
);
   import flash_protect_pkg::*;

   // ----------
   // Functions
   // ----------
   // Hsiao column for data bit idx: all weight 3 ascending, then weight 5
   function automatic logic [7:0] hsiao_col(input int idx);
      int         n;
      logic [7:0] r;
      n = 0;
      r = 8'h00;
      for (int w = 3; w <= 5; w += 2) begin
         for (int v = 0; v < 256; v++) begin
            if ($countones(v[7:0]) == w) begin
               if (n == idx) r = v[7:0];
               n++;
            end
         end
      end
      return r;
   endfunction

   // Check bits of one group
   function automatic logic [7:0] hsiao_enc(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (d[i]) c = c ^ hsiao_col(i);
      end
      return c;
   endfunction

   // Address guard decode from size code and low-end select
   function automatic logic guarded(input logic [3:0] size, input logic low,
                                    input logic [`ARRAY_AW-1:0] a);
      logic [`ARRAY_AW-1:0] mask;
      int                   lg;
      lg   = `GUARD_MIN_LOG2 + int'(size) - 1;
      mask = ~((`ARRAY_AW'(1) << lg) - `ARRAY_AW'(1));
      if (size == `SIZE_ALL_CODE)
         return 1'b0;
      else if (size[3] && (size[2] || size[1]))
         return 1'b1;
      else if (low)
         return (a & mask) == '0;
      else
         return (a & mask) == mask;
   endfunction

   // ----------
   // State
   // ----------
   logic                write_permit_latch;   // Write permit latch
   pwr_state_t          pwr_state;            // Active or deep power-down
   logic                reset_armed;          // First half of reset pair seen
   logic [3:0]          protect_size_bits;    // Guard size code
   logic                protect_low_end_select; // Guard from address zero
   logic                ecc_enable;           // ECC engine on
   logic [1:0]          ctrl;                 // Pin select and pin enable
   logic [`IRQ_W-1:0]   irq_status;           // Sticky events
   logic [`IRQ_W-1:0]   irq_enable;           // Event mask
   logic                single_fix_flag;      // Last read corrected a bit
   logic                double_detect_flag;   // Last read saw two bits

   // ----------
   // Command decode
   // ----------
   wire logic is_reset_go  = cmd_in.valid && (cmd_in.code == CMD_RESET_GO) && reset_armed;
   wire logic is_reset_arm = cmd_in.valid && (cmd_in.code == CMD_RESET_ARM);
   wire logic is_release   = cmd_in.valid && (cmd_in.code == CMD_POWER_RELEASE);
   // Power-down drops everything but release and the reset pair
   wire logic cmd_live     = cmd_in.valid && ((pwr_state == PWR_ACTIVE) ||
                             is_release || is_reset_arm || is_reset_go);
   wire logic is_prog      = (cmd_in.code == CMD_PAGE_PROG) || (cmd_in.code == CMD_QUAD_PROG);
   wire logic is_wipe      = (cmd_in.code == CMD_SECTOR_WIPE) ||
                             (cmd_in.code == CMD_BLOCK_WIPE) || (cmd_in.code == CMD_ARRAY_WIPE);
   // Commands that need the write permit
   wire logic is_alter     = cmd_live && (is_prog || is_wipe || (cmd_in.code == CMD_STATUS_WRITE));
   wire logic addr_guarded = guarded(protect_size_bits, protect_low_end_select, cmd_in.addr);
   // Guarded target or whole-array wipe with nonzero size code
   wire logic guard_hit    = ((is_prog || (is_wipe && cmd_in.code != CMD_ARRAY_WIPE)) &&
                              addr_guarded) ||
                             ((cmd_in.code == CMD_ARRAY_WIPE) &&
                              (protect_size_bits != `PROTECT_RESET));
   // Altering command goes ahead only with permit and no guard
   wire logic alter_ok     = is_alter && write_permit_latch && !guard_hit;
   wire logic alter_bad    = is_alter && !alter_ok;
   wire logic do_status_wr = alter_ok && (cmd_in.code == CMD_STATUS_WRITE);
   wire logic do_prog      = alter_ok && (is_prog || is_wipe);
   wire logic ignored      = cmd_in.valid && !cmd_live;

   // ----------
   // ECC read path
   // ----------
   wire logic [7:0] syndrome = hsiao_enc(arr_in.data) ^ arr_in.check;
   // Untouched erased group reads as all ones with no event
   wire logic       erased   = (arr_in.data == `ERASED_GROUP) && (arr_in.check == `ERASED_CHECK);
   wire logic       syn_odd  = ^syndrome;
   logic [63:0]     flip;                    // Data bit to correct
   logic            col_hit;                 // Syndrome names a data bit
   // Locate the failing data bit from the syndrome
   always_comb begin
      flip    = 64'h0000_0000_0000_0000;
      col_hit = 1'b0;
      for (int i = 0; i < 64; i++) begin
         if (hsiao_col(i) == syndrome) begin
            flip[i] = 1'b1;
            col_hit = 1'b1;
         end
      end
   end
   wire logic ecc_chk    = ecc_enable && !erased && (syndrome != 8'h00);
   wire logic single_err = ecc_chk && syn_odd && (col_hit || ($countones(syndrome) == 1));
   wire logic double_err = ecc_chk && !single_err;
   wire logic [63:0] fixed_data = single_err ? (arr_in.data ^ flip) : arr_in.data;
   // Pin event by selected kind, only with ECC on and pin configured
   wire logic pin_event  = ecc_enable && ctrl[`CTRL_PIN_EN_BIT] &&
                           (ctrl[`CTRL_PIN_SEL_BIT] ? double_err : single_err);

   // ----------
   // Register port decode
   // ----------
   wire logic wr_ctrl  = reg_wr_in && (reg_addr_in == `REG_CTRL);
   wire logic wr_ien   = reg_wr_in && (reg_addr_in == `REG_IRQ_ENABLE);
   wire logic wr_iclr  = reg_wr_in && (reg_addr_in == `REG_IRQ_CLEAR);
   wire logic [31:0] status_word = {22'h000000, double_detect_flag, single_fix_flag,
                                    protect_size_bits, protect_low_end_select, ecc_enable,
                                    (pwr_state == PWR_DOWN), write_permit_latch};
   logic [31:0] next_rdata;                  // Read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `REG_CTRL:       next_rdata = {30'h0000_0000, ctrl};
            `REG_STATUS:     next_rdata = status_word;
            `REG_IRQ_STATUS: next_rdata = {28'h000_0000, irq_status};
            `REG_IRQ_ENABLE: next_rdata = {28'h000_0000, irq_enable};
            default:         next_rdata = 32'h0000_0000;
         endcase
      end
   end
   wire logic [`IRQ_W-1:0] irq_events = {double_err & arr_in.valid, single_err & arr_in.valid,
                                         alter_bad & guard_hit, alter_bad | ignored};
   // Set wins over a clear in the same cycle
   wire logic [`IRQ_W-1:0] next_irq_status =
      (irq_status & ~(wr_iclr ? reg_wdata_in[`IRQ_W-1:0] : '0)) | irq_events;

   // ----------
   // Write permit latch and power state
   // ----------
   // Set by its command, cleared by reset pair, clear command or any alter
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         write_permit_latch <= 1'b0;
      end else if (is_reset_go || (cmd_live && cmd_in.code == CMD_LATCH_CLEAR) || is_alter) begin
         write_permit_latch <= 1'b0;
      end else if (cmd_live && cmd_in.code == CMD_LATCH_SET) begin
         write_permit_latch <= 1'b1;
      end
   end

   // Deep power-down entry and exit
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pwr_state <= PWR_ACTIVE;
      end else begin
         case (pwr_state)
            PWR_ACTIVE: if (cmd_live && cmd_in.code == CMD_POWER_DOWN) pwr_state <= PWR_DOWN;
            PWR_DOWN:   if (is_release || is_reset_go) pwr_state <= PWR_ACTIVE;
            default:    pwr_state <= PWR_ACTIVE;
         endcase
      end
   end

   // Reset pair: arm, then any other command disarms
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) reset_armed <= 1'b0;
      else if (cmd_in.valid) reset_armed <= is_reset_arm;
   end

   // ----------
   // Status-write fields
   // ----------
   // Guard settings and ECC enable, loaded by an accepted status write
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         protect_size_bits      <= `PROTECT_RESET;
         protect_low_end_select <= 1'b0;
         ecc_enable             <= 1'b0;
      end else if (do_status_wr) begin
         protect_size_bits      <= cmd_in.data[`SW_SIZE_LSB +: 4];
         protect_low_end_select <= cmd_in.data[`SW_LOW_END_BIT];
         ecc_enable             <= cmd_in.data[`SW_ECC_EN_BIT];
      end
   end

   // ----------
   // Command answer and program request
   // ----------
   // Accepted program carries its check bits toward the spare area
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_accept_out <= 1'b0;
         cmd_reject_out <= 1'b0;
         prog_out       <= '0;
      end else begin
         cmd_accept_out <= cmd_live && !alter_bad;
         cmd_reject_out <= alter_bad || ignored;
         prog_out.valid <= do_prog;
         prog_out.wipe  <= is_wipe;
         prog_out.addr  <= {cmd_in.addr[`ARRAY_AW-1:3], 3'h0};
         prog_out.data  <= cmd_in.data;
         prog_out.check <= ecc_enable ? hsiao_enc(cmd_in.data) : `ERASED_CHECK;
      end
   end

   // ----------
   // Read output, flags and event pin
   // ----------
   // Each group forwarded with no alignment need on the read address
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_valid_out         <= 1'b0;
         rd_data_out          <= `ERASED_GROUP;
         ecc_event_pin_oe_out <= 1'b0;
      end else begin
         rd_valid_out         <= arr_in.valid;
         rd_data_out          <= fixed_data;
         ecc_event_pin_oe_out <= arr_in.valid && pin_event;
      end
   end

   // Flags of the most recent read, cleared by a read command; a group in the same cycle wins
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         single_fix_flag    <= 1'b0;
         double_detect_flag <= 1'b0;
      end else if (arr_in.valid) begin
         single_fix_flag    <= single_fix_flag | single_err;
         double_detect_flag <= double_detect_flag | double_err;
      end else if (cmd_live && cmd_in.code == CMD_READ) begin
         single_fix_flag    <= 1'b0;
         double_detect_flag <= 1'b0;
      end
   end
   assign single_fix_flag_out    = single_fix_flag;
   assign double_detect_flag_out = double_detect_flag;
   assign ecc_event_pin_o_out    = 1'b0;

   // ----------
   // Register file and interrupt
   // ----------
   // Control, mask, sticky events, read data and interrupt level
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl          <= `CTRL_RESET;
         irq_enable    <= '0;
         irq_status    <= '0;
         reg_rdata_out <= 32'h0000_0000;
         irq_out       <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl <= reg_wdata_in[1:0];
         if (wr_ien)  irq_enable <= reg_wdata_in[`IRQ_W-1:0];
         irq_status    <= next_irq_status;
         reg_rdata_out <= next_rdata;
         irq_out       <= |(next_irq_status & (wr_ien ? reg_wdata_in[`IRQ_W-1:0] : irq_enable));
      end
   end
endmodule
`default_nettype wire

//--- sim/flash_array_model.sv
// Array model beside the protect block: keeps groups and spare bits.
// Assumes the design package and the shared core clock.
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_consts.svh"
module flash_array_model (
   // Clock and program traffic
   input  wire logic                         core_clk_in,
   input  wire flash_protect_pkg::prog_req_t prog_in,
   // Read requests from the bench
   input  wire logic                         rd_go_in,
   input  wire logic [24:0]                  rd_addr_in,
   input  wire logic [63:0]                  flip_in,
   // Group toward the block
   output flash_protect_pkg::arr_group_t     arr_out
);
   import flash_protect_pkg::*;
   logic [71:0] mem [logic [24:0]]; // Groups with spare bits
   // ----------
   // Store programs; answer a read one cycle after the request
   // ----------
   initial arr_out = '0;
   always @(posedge core_clk_in) begin
      logic [71:0] grp;
      grp = {`ERASED_GROUP, `ERASED_CHECK}; // Unwritten groups read erased
      if (mem.exists({rd_addr_in[24:3], 3'h0})) begin
         grp = mem[{rd_addr_in[24:3], 3'h0}];
      end
      if (prog_in.valid && prog_in.wipe) begin
         mem.delete(prog_in.addr); // Wiped group back to erased
      end else if (prog_in.valid) begin
         mem[prog_in.addr] = {prog_in.data, prog_in.check}; // Spare bits kept
      end
      if (rd_go_in) begin
         arr_out <= '{1'b1, grp[71:8] ^ flip_in, grp[7:0]};
      end else begin
         arr_out <= '{1'b0, ~arr_out.data, ~arr_out.check}; // Released lines toggle
      end
   end
endmodule
`default_nettype wire

//--- sim/flash_protect_assertions.sv
// Port checker of the protect block, bound to its top module.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_consts.svh"
module flash_protect_checker (
   // Clock, reset and register port
   input wire logic                           core_clk_in,
   input wire logic                           nrst_in,
   input wire logic [3:0]                     reg_addr_in,
   input wire logic [31:0]                    reg_wdata_in,
   input wire logic                           reg_wr_in,
   // Commands and array traffic
   input wire flash_protect_pkg::cmd_req_t    cmd_in,
   input wire logic                           cmd_accept_out,
   input wire logic                           cmd_reject_out,
   input wire flash_protect_pkg::prog_req_t   prog_out,
   input wire flash_protect_pkg::arr_group_t  arr_in,
   // Read results and events
   input wire logic                           rd_valid_out,
   input wire logic [63:0]                    rd_data_out,
   input wire logic                           single_fix_flag_out,
   input wire logic                           double_detect_flag_out,
   input wire logic                           ecc_event_pin_o_out,
   input wire logic                           ecc_event_pin_oe_out,
   input wire logic                           irq_out
);
   import flash_protect_pkg::*;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   // Program taken and accepted
   sequence s_prog_taken;
      cmd_in.valid && cmd_in.code == CMD_PAGE_PROG ##1 cmd_accept_out;
   endsequence
   // Next program with no latch set between
   sequence s_prog_cmd;
      cmd_in.valid && cmd_in.code == CMD_PAGE_PROG;
   endsequence
   a_latch_spent:
      assert property (s_prog_taken ##1 !(cmd_in.valid && cmd_in.code == CMD_LATCH_SET)
         ##1 s_prog_cmd |=> cmd_reject_out)
      else $error("second program accepted");
   a_cmd_answer:
      assert property (cmd_in.valid |=> cmd_accept_out ^ cmd_reject_out)
      else $error("command answer wrong");
   a_reject_quiet:
      assert property (cmd_reject_out |-> !prog_out.valid)
      else $error("refused command programmed");
   a_prog_group:
      assert property (prog_out.valid |-> cmd_accept_out && prog_out.addr[2:0] == 3'h0)
      else $error("bad program group");
   a_read_latency:
      assert property (rd_valid_out == $past(arr_in.valid))
      else $error("read result late");
   a_erased_clean:
      assert property (arr_in.valid && arr_in.data == `ERASED_GROUP
         && arr_in.check == `ERASED_CHECK |=> rd_data_out == `ERASED_GROUP && !ecc_event_pin_oe_out)
      else $error("erased group not clean");
   a_pin_open_drain:
      assert property (ecc_event_pin_o_out == 1'b0)
      else $error("event pin driven high");
   a_pin_in_group:
      assert property (ecc_event_pin_oe_out |-> rd_valid_out
         && (single_fix_flag_out || double_detect_flag_out))
      else $error("event pin low wrongly");
   a_irq_masked:
      assert property (reg_wr_in && reg_addr_in == `REG_IRQ_ENABLE && reg_wdata_in[3:0] == 4'h0
         |=> ##1 !irq_out)
      else $error("masked interrupt high");
endmodule
bind flash_write_protect_ecc flash_protect_checker u_chk (.*);
`default_nettype wire

//--- sim/flash_write_protect_ecc_test.sv
// Self-checking bench of the write protection and ECC block.
// Assumes design package, array model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_consts.svh"
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
   $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module flash_write_protect_ecc_test;
   import flash_protect_pkg::*;
   localparam logic [63:0] PAT = 64'h0123_4567_89AB_CDEF; // Program payload
   logic clk = 1'b0, nrst = 1'b0, reg_wr, reg_rd, accept, reject; // Clock, reset, strobes
   logic rd_valid, sfix, ddet, pin_o, pin_oe, irq, rd_go;           // Results, model request
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [24:0] rd_addr;
   logic [63:0] rd_data, flip;
   cmd_req_t cmd;
   prog_req_t prog;
   arr_group_t arr;
   int fail_count, comparisons;
   flash_write_protect_ecc u_dut (.core_clk_in(clk), .nrst_in(nrst), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
      .cmd_in(cmd), .cmd_accept_out(accept), .cmd_reject_out(reject), .prog_out(prog),
      .arr_in(arr), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .single_fix_flag_out(sfix),
      .double_detect_flag_out(ddet), .ecc_event_pin_o_out(pin_o),
      .ecc_event_pin_oe_out(pin_oe), .irq_out(irq));
   flash_array_model u_array (.core_clk_in(clk), .prog_in(prog), .rd_go_in(rd_go),
      .rd_addr_in(rd_addr), .flip_in(flip), .arr_out(arr));
   always #50 clk = ~clk;
   // One command, answer judged in the following cycle
   task automatic send(input cmd_code_t c, input logic [24:0] a, input logic [63:0] d,
                       input logic acc);
      @(posedge clk);
      cmd <= '{1'b1, c, a, d};
      @(posedge clk);
      cmd <= '{1'b0, CMD_NONE, ~a, ~d};
      #1;
      `CHK("accept", acc, accept)
      `CHK("reject", !acc, reject)
   endtask
   task automatic op(input cmd_code_t c, input logic acc);
      send(c, 25'h0, 64'h0, acc);
   endtask
   task automatic arm;
      op(CMD_LATCH_SET, 1'b1);
   endtask
   task automatic set_status(input logic [5:0] v);
      arm();
      send(CMD_STATUS_WRITE, 25'h0, {58'h0, v}, 1'b1);
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_expect(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("register", e, reg_rdata & m)
   endtask
   task automatic irq_expect(input logic e);
      @(posedge clk);
      #1;
      `CHK("interrupt", e, irq)
   endtask
   // Group read through the model, optionally with flipped bits
   task automatic rd_group(input logic [24:0] a, input logic [63:0] f, input logic [63:0] e,
                           input logic s, input logic dd, input logic oe);
      @(posedge clk);
      rd_go <= 1'b1;
      rd_addr <= a;
      flip <= f;
      @(posedge clk);
      rd_go <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("read valid", 1'b1, rd_valid)
      if (!dd) `CHK("read data", e, rd_data)
      `CHK("single flag", s, sfix)
      `CHK("double flag", dd, ddet)
      `CHK("event pin", oe, pin_oe)
   endtask
   task automatic test_latch;
      cmd_code_t alters [6] = '{CMD_STATUS_WRITE, CMD_PAGE_PROG, CMD_QUAD_PROG,
                                CMD_SECTOR_WIPE, CMD_BLOCK_WIPE, CMD_ARRAY_WIPE};
      reg_expect(`REG_STATUS, 32'h3FF, 32'h0);
      reg_expect(4'hF, 32'hFFFF_FFFF, 32'h0);
      send(CMD_PAGE_PROG, 25'h100, PAT, 1'b0);
      reg_expect(`REG_IRQ_STATUS, 32'h1, 32'h1);
      arm();
      reg_expect(`REG_STATUS, 32'h1, 32'h1);
      op(CMD_LATCH_CLEAR, 1'b1);
      reg_expect(`REG_STATUS, 32'h1, 32'h0);
      foreach (alters[i]) begin
         arm();
         send(alters[i], 25'h200 + 25'(i * 8), 64'h0, 1'b1);
         reg_expect(`REG_STATUS, 32'h1, 32'h0);
      end
      arm();
      send(CMD_PAGE_PROG, 25'h300, PAT, 1'b1);
      `CHK("spare bits", 8'hFF, prog.check)
      send(CMD_PAGE_PROG, 25'h308, PAT, 1'b0);
      arm();
      op(CMD_RESET_ARM, 1'b1);
      op(CMD_RESET_GO, 1'b1);
      reg_expect(`REG_STATUS, 32'h1, 32'h0);
   endtask
   task automatic test_guard;
      logic [25:0] size;
      for (int lo = 0; lo < 2; lo++) begin
         for (int code = 0; code < 16; code++) begin
            size = (code < 10) ? 26'h1 << (15 + code) : 26'h0;
            set_status({1'b0, lo[0], code[3:0]});
            arm();
            send(CMD_PAGE_PROG, lo ? 25'h0 : 25'(26'h200_0000 - size), PAT, code == 0);
            if (code > 0 && code < 10) begin
               arm();
               send(CMD_PAGE_PROG, lo ? size[24:0] : 25'(26'h1FF_FFF8 - size), PAT, 1'b1);
            end
            arm();
            op(CMD_ARRAY_WIPE, code == 0);
         end
      end
      reg_expect(`REG_IRQ_STATUS, 32'h2, 32'h2);
      set_status(6'h0);
   endtask
   task automatic test_power;
      for (int k = 0; k < 2; k++) begin
         op(CMD_POWER_DOWN, 1'b1);
         reg_expect(`REG_STATUS, 32'h2, 32'h2);
         op(CMD_LATCH_SET, 1'b0);
         op(k ? CMD_RESET_ARM : CMD_READ, k == 1);
         op(k ? CMD_RESET_GO : CMD_POWER_RELEASE, 1'b1);
         reg_expect(`REG_STATUS, 32'h2, 32'h0);
      end
   endtask
   task automatic test_ecc;
      reg_write(`REG_CTRL, 32'h2);
      reg_write(`REG_IRQ_ENABLE, 32'h4);
      set_status(6'h20);
      arm();
      send(CMD_PAGE_PROG, 25'h400, PAT, 1'b1);
      rd_group(25'h403, 64'h200, PAT, 1'b1, 1'b0, 1'b1);
      reg_expect(`REG_IRQ_STATUS, 32'h4, 32'h4);
      `CHK("interrupt", 1'b1, irq)
      reg_write(`REG_IRQ_CLEAR, 32'h4);
      irq_expect(1'b0);
      send(CMD_READ, 25'h1_2345, 64'h0, 1'b1);
      `CHK("single flag", 1'b0, sfix)
      reg_write(`REG_CTRL, 32'h3);
      rd_group(25'h400, 64'h200, PAT, 1'b1, 1'b0, 1'b0);
      op(CMD_READ, 1'b1);
      rd_group(25'h400, 64'h1_0000_0008, PAT, 1'b0, 1'b1, 1'b1);
      op(CMD_READ, 1'b1);
      rd_group(25'h800, 64'h0, `ERASED_GROUP, 1'b0, 1'b0, 1'b0);
      set_status(6'h0);
      reg_write(`REG_CTRL, 32'h2);
      rd_group(25'h400, 64'h200, PAT ^ 64'h200, 1'b0, 1'b0, 1'b0);
      reg_write(`REG_IRQ_ENABLE, 32'h1);
      irq_expect(1'b1);
      reg_write(`REG_IRQ_ENABLE, 32'h0);
      irq_expect(1'b0);
   endtask
   task automatic complete_run;
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      {reg_wr, reg_rd, rd_go, reg_addr, reg_wdata, rd_addr, flip} = '0;
      cmd = '0;
      fail_count = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      test_latch();
      test_guard();
      test_power();
      test_ecc();
      complete_run();
   end
   initial begin
      repeat (6000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule
`default_nettype wire
